// file: mcm_pkg.sv
// Purpose: shared constants for the memory checksum monitor
// Assumes: 8-bit register port, 16-bit checksum, byte-wide memory reads
// Notes: offsets are word indices on the plain register port
package mcm_pkg;
  localparam logic [3:0] MCM_REG_CTRL = 4'h0;
  localparam logic [3:0] MCM_REG_STAT = 4'h1;
  localparam logic [3:0] MCM_REG_MASK = 4'h2;
  localparam logic [3:0] MCM_REG_SUM_H = 4'h3;
  localparam logic [3:0] MCM_REG_SUM_L = 4'h4;
  localparam logic [3:0] MCM_REG_REF_H = 4'h5;
  localparam logic [3:0] MCM_REG_REF_L = 4'h6;
  localparam logic [3:0] MCM_REG_START_H = 4'h7;
  localparam logic [3:0] MCM_REG_START_L = 4'h8;
  localparam logic [3:0] MCM_REG_END_H = 4'h9;
  localparam logic [3:0] MCM_REG_END_L = 4'hA;
  // control fields
  localparam int MCM_CTRL_TYPE_LSB = 0;
  localparam int MCM_CTRL_GO_BIT = 3;
  // status fields: bit0 sticky done flag, bit1 mismatch, bit2 busy
  localparam int MCM_STAT_DONE_BIT = 0;
  localparam int MCM_STAT_FAIL_BIT = 1;
  localparam int MCM_STAT_BUSY_BIT = 2;
  localparam logic [2:0] MCM_TYPE_MON_FLASH = 3'h4;
  localparam logic [2:0] MCM_TYPE_MON_RAM = 3'h5;
  localparam logic [2:0] MCM_TYPE_VAL_FLASH = 3'h6;
  localparam logic [2:0] MCM_TYPE_VAL_RAM = 3'h7;
  localparam logic [15:0] MCM_POLY = 16'h1021;
  localparam logic [7:0] MCM_RESET_BYTE = 8'h00;
  localparam logic [15:0] MCM_RESET_WORD = 16'h0000;
endpackage : mcm_pkg

// file: mcm_crc_step.sv
// Purpose: one-byte update of the 16-bit checksum
// Assumes: msb-first shifting, fixed polynomial
// Notes: purely combinational
`timescale 1ns/1ps
module mcm_crc_step
  import mcm_pkg::*;
(
  // data
  input wire logic [15:0] crc_in,
  input wire logic [7:0] byte_in,
  output logic [15:0] crc_out
);
  logic [15:0] stage [0:8];
  assign stage[0] = crc_in;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_bit
      logic fb;
      assign fb = stage[gi][15] ^ byte_in[7 - gi];
      assign stage[gi + 1] = {stage[gi][14:0], 1'b0} ^ (fb ? MCM_POLY : 16'h0000);
    end
  endgenerate
  assign crc_out = stage[8];
endmodule : mcm_crc_step

// file: mcm_mem_port.sv
// Purpose: byte read sequencer for the selected memory region
// Assumes: memory answers one cycle after the request
// Notes: steps addresses upward from start to end inclusive
`timescale 1ns/1ps
module mcm_mem_port
  import mcm_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  // control
  input wire logic start_in,
  input wire logic [15:0] start_addr_in,
  input wire logic [15:0] end_addr_in,
  // memory
  output logic rd_out,
  output logic [15:0] addr_out,
  input wire logic [7:0] data_in,
  // stream
  output logic byte_vld_out,
  output logic [7:0] byte_out,
  output logic last_out
);
  logic active_q;
  logic pend_q;
  logic pend_last_q;
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      active_q <= 1'b0;
      addr_out <= MCM_RESET_WORD;
    end else if (clk_en_in) begin
      if (start_in) begin
        active_q <= 1'b1;
        addr_out <= start_addr_in;
      end else if (active_q) begin
        if (addr_out == end_addr_in) begin
          active_q <= 1'b0;
        end else begin
          addr_out <= addr_out + 16'h0001;
        end
      end
    end
  end
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      pend_q <= 1'b0;
      pend_last_q <= 1'b0;
    end else if (clk_en_in) begin
      pend_q <= active_q;
      pend_last_q <= active_q && (addr_out == end_addr_in);
    end
  end
  assign rd_out = active_q;
  assign byte_vld_out = pend_q;
  assign byte_out = data_in;
  assign last_out = pend_last_q;
endmodule : mcm_mem_port

// file: mcm_monitor.sv
// Purpose: one-shot memory checksum monitor and validator
// Assumes: register port with read data one cycle after the read strobe
// Notes: flash and data ram share one byte read pin set, region picked by type
`timescale 1ns/1ps
// Behaviour
// - A check runs once and the engine then stays in MCM_DONE until reset, never restarting itself.
// - In monitor mode the done flag is set when the read pass ends, whatever the result.
// - In validate mode the done flag is set only when the pass ends and the compare fails.
// - At the end of a pass the mismatch status bit is updated with the compare outcome.
// - A set done flag with its interrupt enabled raises the interrupt request.
// - The done flag stays set until software clears it; hardware never clears it.
// - Type values 0 to 3 are unsupported and start nothing.
// - Validation compares the computed checksum with the loaded reference; any difference fails.
// - Types decode as 4 monitor flash, 5 monitor ram, 6 validate flash, 7 validate ram; a fail resets the checksum.
module mcm_monitor
  import mcm_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  // register port
  input wire logic [3:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // memory side
  output logic flash_rd_out,
  output logic ram_rd_out,
  output logic [15:0] mem_addr_out,
  input wire logic [7:0] mem_data_in,
  // interrupt
  output logic irq_out
);
  typedef enum logic [1:0] {MCM_IDLE, MCM_RUN, MCM_DONE} mcm_state_t;

  function automatic logic type_valid(input logic [2:0] t);
    type_valid = t[2];
  endfunction : type_valid

  function automatic logic type_is_val(input logic [2:0] t);
    type_is_val = t[1];
  endfunction : type_is_val

  function automatic logic type_is_ram(input logic [2:0] t);
    type_is_ram = t[0];
  endfunction : type_is_ram

  mcm_state_t state_q;
  logic [2:0] type_q;
  logic done_q;
  logic fail_q;
  logic mask_q;
  logic [15:0] sum_q;
  logic [15:0] ref_q;
  logic [15:0] start_q;
  logic [15:0] end_q;
  logic [15:0] sum_next;
  logic go;
  logic byte_vld;
  logic [7:0] byte_val;
  logic last;
  logic rd;
  logic [15:0] addr;
  logic pass_end;
  logic mismatch;
  logic wr_ctrl;
  logic [2:0] wr_type;

  assign wr_ctrl = reg_wr_in && (reg_addr_in == MCM_REG_CTRL);
  assign wr_type = reg_wdata_in[MCM_CTRL_TYPE_LSB +: 3];
  assign go = wr_ctrl && reg_wdata_in[MCM_CTRL_GO_BIT] && type_valid(wr_type)
    && (state_q == MCM_IDLE);

  mcm_mem_port u_port (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .clk_en_in(clk_en_in),
    .start_in(go),
    .start_addr_in(start_q),
    .end_addr_in(end_q),
    .rd_out(rd),
    .addr_out(addr),
    .data_in(mem_data_in),
    .byte_vld_out(byte_vld),
    .byte_out(byte_val),
    .last_out(last)
  );

  mcm_crc_step u_step (
    .crc_in(sum_q),
    .byte_in(byte_val),
    .crc_out(sum_next)
  );

  assign pass_end = byte_vld && last;
  assign mismatch = (sum_next != ref_q);

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      state_q <= MCM_IDLE;
      type_q <= 3'h0;
    end else if (clk_en_in) begin
      case (state_q)
        MCM_IDLE: begin
          if (go) begin
            state_q <= MCM_RUN;
            type_q <= wr_type;
          end
        end
        MCM_RUN: begin
          if (pass_end) begin
            state_q <= MCM_DONE;
          end
        end
        MCM_DONE: state_q <= MCM_DONE;
        default: state_q <= MCM_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      sum_q <= MCM_RESET_WORD;
    end else if (clk_en_in) begin
      if (state_q == MCM_RUN && byte_vld) begin
        if (last && mismatch) begin
          sum_q <= MCM_RESET_WORD;
        end else begin
          sum_q <= sum_next;
        end
      end else if (reg_wr_in && reg_addr_in == MCM_REG_SUM_H) begin
        sum_q[15:8] <= reg_wdata_in;
      end else if (reg_wr_in && reg_addr_in == MCM_REG_SUM_L) begin
        sum_q[7:0] <= reg_wdata_in;
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      ref_q <= MCM_RESET_WORD;
      start_q <= MCM_RESET_WORD;
      end_q <= MCM_RESET_WORD;
      mask_q <= 1'b0;
    end else if (clk_en_in && reg_wr_in) begin
      case (reg_addr_in)
        MCM_REG_REF_H: ref_q[15:8] <= reg_wdata_in;
        MCM_REG_REF_L: ref_q[7:0] <= reg_wdata_in;
        MCM_REG_START_H: start_q[15:8] <= reg_wdata_in;
        MCM_REG_START_L: start_q[7:0] <= reg_wdata_in;
        MCM_REG_END_H: end_q[15:8] <= reg_wdata_in;
        MCM_REG_END_L: end_q[7:0] <= reg_wdata_in;
        MCM_REG_MASK: mask_q <= reg_wdata_in[MCM_STAT_DONE_BIT];
        default: mask_q <= mask_q;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      fail_q <= 1'b0;
    end else if (clk_en_in && state_q == MCM_RUN && pass_end) begin
      fail_q <= mismatch;
    end
  end

  // sticky done, set wins over write-one clear
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      done_q <= 1'b0;
    end else if (clk_en_in) begin
      if (state_q == MCM_RUN && pass_end && (!type_is_val(type_q) || mismatch)) begin
        done_q <= 1'b1;
      end else if (reg_wr_in && reg_addr_in == MCM_REG_STAT
                   && reg_wdata_in[MCM_STAT_DONE_BIT]) begin
        done_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      irq_out <= 1'b0;
    end else if (clk_en_in) begin
      irq_out <= done_q && mask_q;
    end
  end

  // region select; outputs registered from the sequencer
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      flash_rd_out <= 1'b0;
      ram_rd_out <= 1'b0;
      mem_addr_out <= MCM_RESET_WORD;
    end else if (clk_en_in) begin
      flash_rd_out <= rd && !type_is_ram(type_q);
      ram_rd_out <= rd && type_is_ram(type_q);
      mem_addr_out <= addr;
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      reg_rdata_out <= MCM_RESET_BYTE;
    end else if (clk_en_in) begin
      reg_rdata_out <= MCM_RESET_BYTE;
      if (reg_rd_in) begin
        case (reg_addr_in)
          MCM_REG_CTRL: reg_rdata_out <= {5'h00, type_q};
          MCM_REG_STAT: reg_rdata_out <= {5'h00, state_q == MCM_RUN, fail_q, done_q};
          MCM_REG_MASK: reg_rdata_out <= {7'h00, mask_q};
          MCM_REG_SUM_H: reg_rdata_out <= sum_q[15:8];
          MCM_REG_SUM_L: reg_rdata_out <= sum_q[7:0];
          MCM_REG_REF_H: reg_rdata_out <= ref_q[15:8];
          MCM_REG_REF_L: reg_rdata_out <= ref_q[7:0];
          MCM_REG_START_H: reg_rdata_out <= start_q[15:8];
          MCM_REG_START_L: reg_rdata_out <= start_q[7:0];
          MCM_REG_END_H: reg_rdata_out <= end_q[15:8];
          MCM_REG_END_L: reg_rdata_out <= end_q[7:0];
          default: reg_rdata_out <= MCM_RESET_BYTE;
        endcase
      end
    end
  end
endmodule : mcm_monitor

// file: mcm_mem_model.sv
// Purpose: behavioural flash and data ram read by the monitor
// Assumes: byte answer is combinational from the registered address
// Notes: contents are a fixed function of the address
`timescale 1ns/1ps
module mcm_mem_model (
  // request
  input wire logic clk_sys_in,
  input wire logic flash_rd_in,
  input wire logic ram_rd_in,
  input wire logic [15:0] addr_in,
  // answer
  output logic [7:0] data_out
);
  // known start so the idle toggle is not stuck at unknown
  logic [7:0] last_q = 8'h00;
  always_comb begin
    if (flash_rd_in) data_out = addr_in[7:0] ^ addr_in[15:8] ^ 8'hA5;
    else if (ram_rd_in) data_out = ~addr_in[7:0];
    // idle bus toggles so a late sample never looks valid
    else data_out = ~last_q;
  end
  always_ff @(posedge clk_sys_in) last_q <= data_out;
endmodule : mcm_mem_model

// file: mcm_monitor_asserts.sv
// Purpose: port-level checks of the checksum monitor
// Assumes: clk_en_in held high
// Notes: helper state tracks mask, first accepted go and end of pass
`timescale 1ns/1ps
module mcm_monitor_asserts
  import mcm_pkg::*;
(
  // watched ports
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic flash_rd_out,
  input wire logic ram_rd_out,
  input wire logic [15:0] mem_addr_out,
  input wire logic [7:0] mem_data_in,
  input wire logic irq_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  logic mask_q, went_q, ended_q, rd_q;
  wire logic any_rd = flash_rd_out | ram_rd_out;
  wire logic ctl_wr = reg_wr_in && reg_addr_in == MCM_REG_CTRL && reg_wdata_in[3];
  wire logic go_ok = ctl_wr && reg_wdata_in[2] && !went_q;
  wire logic clr_ev = reg_wr_in && ((reg_addr_in == MCM_REG_STAT && reg_wdata_in[0])
    || (reg_addr_in == MCM_REG_MASK && !reg_wdata_in[0]));
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      mask_q <= 1'b0;
      went_q <= 1'b0;
      ended_q <= 1'b0;
      rd_q <= 1'b0;
    end else if (clk_en_in) begin
      if (reg_wr_in && reg_addr_in == MCM_REG_MASK) mask_q <= reg_wdata_in[0];
      if (go_ok) went_q <= 1'b1;
      if (rd_q && !any_rd) ended_q <= 1'b1;
      rd_q <= any_rd;
    end
  end
  property p_one_src; !(flash_rd_out && ram_rd_out); endproperty
  a_one_src: assert property (p_one_src) else $error("both regions read");
  property p_rd_idle; (!reg_rd_in && clk_en_in) |=> reg_rdata_out == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_step; any_rd ##1 any_rd |-> mem_addr_out == $past(mem_addr_out) + 16'h0001; endproperty
  a_step: assert property (p_step) else $error("address not ascending");
  property p_bad; (ctl_wr && !reg_wdata_in[2] && !went_q) |=> !any_rd [*3]; endproperty
  a_bad: assert property (p_bad) else $error("bad type started");
  property p_go_fl; (go_ok && !reg_wdata_in[0]) |-> ##[1:3] flash_rd_out; endproperty
  a_go_fl: assert property (p_go_fl) else $error("flash pass missing");
  property p_go_ram; (go_ok && reg_wdata_in[0]) |-> ##[1:3] ram_rd_out; endproperty
  a_go_ram: assert property (p_go_ram) else $error("ram pass missing");
  property p_once; ended_q |-> !any_rd; endproperty
  a_once: assert property (p_once) else $error("pass restarted");
  property p_masked; !mask_q [*2] |-> !irq_out; endproperty
  a_masked: assert property (p_masked) else $error("masked irq high");
  property p_fall; $fell(irq_out) |-> $past(clr_ev, 2); endproperty
  a_fall: assert property (p_fall) else $error("irq dropped alone");
endmodule : mcm_monitor_asserts
bind mcm_monitor mcm_monitor_asserts u_chk (.clk_sys_in, .reset_in, .clk_en_in, .reg_addr_in,
  .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .flash_rd_out, .ram_rd_out,
  .mem_addr_out, .mem_data_in, .irq_out);

// file: tb_top.sv
// Purpose: random and corner runs of the checksum monitor
// Assumes: one pass per reset, so each case starts from reset
// Notes: expected checksum is rebuilt byte by byte here
`timescale 1ns/1ps
module tb_top import mcm_pkg::*; ;
  logic clk_sys_in = 1'b0, reset_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0, irq_out;
  logic flash_rd_out, ram_rd_out;
  logic [3:0] reg_addr_in = 4'h0;
  logic [7:0] reg_wdata_in = 8'h00, reg_rdata_out, mem_data_in, v;
  logic [15:0] mem_addr_out;
  logic [31:0] seed = 32'h764EC413;
  int error_cnt = 0, comparisons = 0;
  mcm_monitor dut (.clk_sys_in, .reset_in, .clk_en_in(1'b1), .reg_addr_in, .reg_wdata_in,
    .reg_wr_in, .reg_rd_in, .reg_rdata_out, .flash_rd_out, .ram_rd_out, .mem_addr_out,
    .mem_data_in, .irq_out);
  mcm_mem_model u_mem (.clk_sys_in, .flash_rd_in(flash_rd_out), .ram_rd_in(ram_rd_out),
    .addr_in(mem_addr_out), .data_out(mem_data_in));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  function automatic logic [15:0] step(logic [15:0] c, logic [7:0] b);
    c = c ^ {b, 8'h00};
    for (int k = 0; k < 8; k++) c = c[15] ? ((c << 1) ^ MCM_POLY) : (c << 1);
    return c;
  endfunction : step
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask : wr
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // read data stand only in the cycle after the strobe
  task automatic rd(logic [3:0] a);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1 v = reg_rdata_out;
  endtask : rd
  task automatic rchk(string n, logic [3:0] a, logic [7:0] e);
    rd(a);
    chk(n, e, v);
  endtask : rchk
  task automatic rst();
    reset_in <= 1'b1;
    repeat (10) @(posedge clk_sys_in);
    reset_in <= 1'b0;
  endtask : rst
  task automatic conclude();
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  initial begin
    forever #10 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    logic [2:0] ty;
    logic [31:0] r;
    logic [15:0] st, en, crc, rf, a;
    logic [47:0] w;
    logic m, ok, dn;
    rst();
    wr(4'hF, 8'hFF);
    rchk("unmapped", 4'hF, 8'h00);
    rchk("sum_l", MCM_REG_SUM_L, 8'h00);
    for (int t = 0; t < 4; t++) wr(MCM_REG_CTRL, 8'h08 | t[7:0]);
    repeat (3) @(posedge clk_sys_in);
    rchk("bad type", MCM_REG_STAT, 8'h00);
    for (int i = 0; i < 8; i++) begin
      r = xs();
      ty = 3'h4 + i[1:0];
      ok = i[2];
      m = (i != 1);
      st = {4'h0, r[19:8]};
      en = st + {13'h0000, r[2:0]};
      crc = 16'h0000;
      for (a = st; a <= en; a++) crc = step(crc, ty[0] ? ~a[7:0] : a[7:0] ^ a[15:8] ^ 8'hA5);
      rf = ok ? crc : crc ^ {r[31:24], 8'h01};
      dn = ty[1] ? !ok : 1'b1;
      w = {rf, st, en};
      rst();
      wr(MCM_REG_MASK, {7'h00, m});
      wr(MCM_REG_SUM_H, 8'h00);
      wr(MCM_REG_SUM_L, 8'h00);
      for (int k = 0; k < 6; k++) wr(MCM_REG_REF_H + k[3:0], w[47 - 8 * k -: 8]);
      wr(MCM_REG_CTRL, {5'h01, ty});
      repeat (2) @(posedge clk_sys_in);
      v = 8'h04;
      // busy poll only; the settled status is compared below
      for (int k = 0; k < 100 && v[2] !== 1'b0; k++) rd(MCM_REG_STAT);
      chk("busy", 8'h00, {5'h00, v[2], 2'b00});
      if (v[2] !== 1'b0) begin
        error_cnt++;
        conclude();
      end
      repeat (2) @(posedge clk_sys_in);
      rchk("status", MCM_REG_STAT, {6'h00, !ok, dn});
      rchk("sum_h", MCM_REG_SUM_H, ok ? crc[15:8] : 8'h00);
      rchk("sum_l", MCM_REG_SUM_L, ok ? crc[7:0] : 8'h00);
      chk("irq", {7'h00, dn & m}, {7'h00, irq_out});
      wr(MCM_REG_CTRL, {5'h01, ty});
      repeat (4) @(posedge clk_sys_in);
      rchk("no rerun", MCM_REG_STAT, {6'h00, !ok, dn});
      wr(MCM_REG_STAT, 8'h01);
      repeat (2) @(posedge clk_sys_in);
      rchk("cleared", MCM_REG_STAT, {6'h00, !ok, 1'b0});
      chk("irq off", 8'h00, {7'h00, irq_out});
    end
    conclude();
  end
endmodule : tb_top
